// File: inc/gpt_pkg.sv
package gpt_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and answers
  // ----------------------------------------------------------------
  localparam int          AXIL_AW     = 8;
  localparam int          AXIL_DW     = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [AXIL_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AXIL_AW-1:0] OFS_PERIOD = 8'h04;
  localparam logic [AXIL_AW-1:0] OFS_COUNT  = 8'h08;
  localparam logic [AXIL_AW-1:0] OFS_STATUS = 8'h0c;
  localparam logic [AXIL_AW-1:0] OFS_MASK   = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          CTRL_MODE_LSB   = 1;
  localparam int          CTRL_PRE_LSB    = 6;
  localparam int          CTRL_POST_LSB   = 9;
  localparam int          CTRL_CLKSEL_BIT = 13;
  localparam int          STAT_EVENT_BIT  = 0;
  localparam int          CNT_W           = 8;
  localparam int          PRE_CNT_W       = 7;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [7:0]  PERIOD_RST      = 8'hff;
  localparam logic [7:0]  COUNT_RST       = 8'h00;

  // ----------------------------------------------------------------
  // Timing: gate and run enable pass two external timer clock edges, or one edge with the system clock as timer clock.
  // ----------------------------------------------------------------
  localparam int          SYNC_STAGES     = 2;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_SW_GATE = 5'b00000,
    MODE_HW_HIGH = 5'b00001,
    MODE_HW_LOW  = 5'b00010
  } gpt_mode_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [AXIL_AW-1:0] a);
    addr_hit = (a == OFS_CTRL) || (a == OFS_PERIOD) || (a == OFS_COUNT) ||
               (a == OFS_STATUS) || (a == OFS_MASK);
  endfunction : addr_hit

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : merge_strb

endpackage : gpt_pkg

// File: rtl/gpt_axil.sv
`timescale 1ns/1ps
module gpt_axil
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  // Write address and data
  input  wire logic [AXIL_AW-1:0] i_awaddr,
  input  wire logic               i_awvalid,
  output      logic               o_awready,
  input  wire logic [AXIL_DW-1:0] i_wdata,
  input  wire logic [3:0]         i_wstrb,
  input  wire logic               i_wvalid,
  output      logic               o_wready,
  // Write response
  output      logic [1:0]         o_bresp,
  output      logic               o_bvalid,
  input  wire logic               i_bready,
  // Read address and data
  input  wire logic [AXIL_AW-1:0] i_araddr,
  input  wire logic               i_arvalid,
  output      logic               o_arready,
  output      logic [AXIL_DW-1:0] o_rdata,
  output      logic [1:0]         o_rresp,
  output      logic               o_rvalid,
  input  wire logic               i_rready,
  // Register file side
  output      logic               o_wr_en,
  output      logic [AXIL_AW-1:0] o_wr_addr,
  output      logic [AXIL_DW-1:0] o_wr_data,
  output      logic [3:0]         o_wr_strb,
  output      logic [AXIL_AW-1:0] o_rd_addr,
  input  wire logic [AXIL_DW-1:0] i_rd_data
);

  logic               aw_held_q, aw_held_d;
  logic [AXIL_AW-1:0] aw_addr_q, aw_addr_d;
  logic               w_held_q,  w_held_d;
  logic [AXIL_DW-1:0] w_data_q,  w_data_d;
  logic [3:0]         w_strb_q,  w_strb_d;
  logic               bvalid_q,  bvalid_d;
  logic [1:0]         bresp_q,   bresp_d;
  logic               rvalid_q,  rvalid_d;
  logic [AXIL_DW-1:0] rdata_q,   rdata_d;
  logic [1:0]         rresp_q,   rresp_d;
  logic               aw_take, w_take, have_aw, have_w, do_wr, ar_take;

  assign o_awready = ~aw_held_q & ~bvalid_q;
  assign o_wready  = ~w_held_q & ~bvalid_q;
  assign o_arready = ~rvalid_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;
  assign o_rd_addr = i_araddr;

  // Address and data may arrive in either order; the write fires once
  // both are held or offered.
  always_comb begin
    aw_take   = i_awvalid & o_awready;
    w_take    = i_wvalid & o_wready;
    have_aw   = aw_held_q | aw_take;
    have_w    = w_held_q | w_take;
    do_wr     = have_aw & have_w;
    o_wr_en   = do_wr;
    o_wr_addr = aw_held_q ? aw_addr_q : i_awaddr;
    o_wr_data = w_held_q ? w_data_q : i_wdata;
    o_wr_strb = w_held_q ? w_strb_q : i_wstrb;
    aw_held_d = have_aw & ~do_wr;
    aw_addr_d = o_wr_addr;
    w_held_d  = have_w & ~do_wr;
    w_data_d  = o_wr_data;
    w_strb_d  = o_wr_strb;
    bvalid_d  = bvalid_q & ~i_bready;
    bresp_d   = bresp_q;
    if (do_wr) begin
      bvalid_d = 1'b1;
      bresp_d  = addr_hit(o_wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    ar_take  = i_arvalid & o_arready;
    rvalid_d = rvalid_q & ~i_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rdata_d  = addr_hit(i_araddr) ? i_rd_data : '0;
      rresp_d  = addr_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

endmodule : gpt_axil

// File: rtl/gpt_sync.sv
`timescale 1ns/1ps
module gpt_sync
  import gpt_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] i_d,
  output      logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Only the second stage reads the first.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule : gpt_sync

// File: rtl/gpt_top.sv
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module gpt_top
  import gpt_pkg::*;
(
  // Clock and reset
  input  wire logic               I_CLK,
  input  wire logic               I_SRST,
  // AXI4-Lite write channels
  input  wire logic [AXIL_AW-1:0] I_AWADDR,
  input  wire logic               I_AWVALID,
  output      logic               O_AWREADY,
  input  wire logic [AXIL_DW-1:0] I_WDATA,
  input  wire logic [3:0]         I_WSTRB,
  input  wire logic               I_WVALID,
  output      logic               O_WREADY,
  output      logic [1:0]         O_BRESP,
  output      logic               O_BVALID,
  input  wire logic               I_BREADY,
  // AXI4-Lite read channels
  input  wire logic [AXIL_AW-1:0] I_ARADDR,
  input  wire logic               I_ARVALID,
  output      logic               O_ARREADY,
  output      logic [AXIL_DW-1:0] O_RDATA,
  output      logic [1:0]         O_RRESP,
  output      logic               O_RVALID,
  input  wire logic               I_RREADY,
  // Timer clock and gate pins
  input  wire logic               I_TIMER_CLOCK_INPUT,
  input  wire logic               I_EXTERNAL_GATE_INPUT,
  // Time base for the PWM consumer
  output      logic [CNT_W-1:0]   O_COUNT_VALUE,
  output      logic               O_PERIOD_MATCH,
  output      logic               O_POSTSCALED_MATCH_PULSE,
  // Interrupt
  output      logic               O_IRQ
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic               wr_en;
  logic [AXIL_AW-1:0] wr_addr;
  logic [AXIL_DW-1:0] wr_data;
  logic [3:0]         wr_strb;
  logic [AXIL_AW-1:0] rd_addr;
  logic [AXIL_DW-1:0] rd_data;

  gpt_axil u_axil (
    .i_clk     (I_CLK),
    .i_srst    (I_SRST),
    .i_awaddr  (I_AWADDR),
    .i_awvalid (I_AWVALID),
    .o_awready (O_AWREADY),
    .i_wdata   (I_WDATA),
    .i_wstrb   (I_WSTRB),
    .i_wvalid  (I_WVALID),
    .o_wready  (O_WREADY),
    .o_bresp   (O_BRESP),
    .o_bvalid  (O_BVALID),
    .i_bready  (I_BREADY),
    .i_araddr  (I_ARADDR),
    .i_arvalid (I_ARVALID),
    .o_arready (O_ARREADY),
    .o_rdata   (O_RDATA),
    .o_rresp   (O_RRESP),
    .o_rvalid  (O_RVALID),
    .i_rready  (I_RREADY),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0]      ctrl_q, ctrl_d;
  logic [7:0]       period_q, period_d;
  logic             flag_q, flag_d;
  logic             mask_q, mask_d;
  logic             post_pulse_q;
  logic             run_bit;
  gpt_mode_e        mode;
  logic [2:0]       pre_sel;
  logic [3:0]       post_sel;
  logic             clk_sel;
  logic [31:0]      ctrl_w;

  assign run_bit  = ctrl_q[CTRL_RUN_BIT];
  assign mode     = gpt_mode_e'(ctrl_q[CTRL_MODE_LSB +: 5]);
  assign pre_sel  = ctrl_q[CTRL_PRE_LSB +: 3];
  assign post_sel = ctrl_q[CTRL_POST_LSB +: 4];
  assign clk_sel  = ctrl_q[CTRL_CLKSEL_BIT];

  always_comb begin
    ctrl_w   = merge_strb(ctrl_q, wr_data, wr_strb);
    ctrl_d   = ctrl_q;
    period_d = period_q;
    mask_d   = mask_q;
    flag_d   = flag_q;
    if (wr_en && wr_addr == OFS_CTRL) begin
      ctrl_d = ctrl_w & 32'h0000_3fff;
    end
    if (wr_en && wr_addr == OFS_PERIOD && wr_strb[0]) begin
      period_d = wr_data[7:0];
    end
    if (wr_en && wr_addr == OFS_MASK && wr_strb[0]) begin
      mask_d = wr_data[STAT_EVENT_BIT];
    end
    if (wr_en && wr_addr == OFS_STATUS && wr_strb[0] && wr_data[STAT_EVENT_BIT]) begin
      flag_d = 1'b0;
    end
    // A new event in the clearing cycle wins over the clear.
    if (post_pulse_q) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ctrl_q   <= CTRL_RST;
      period_q <= PERIOD_RST;
      flag_q   <= 1'b0;
      mask_q   <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      period_q <= period_d;
      flag_q   <= flag_d;
      mask_q   <= mask_d;
    end
  end

  logic [CNT_W-1:0] count_q, count_d;

  always_comb begin
    rd_data = '0;
    case (rd_addr)
      OFS_CTRL:   rd_data = ctrl_q;
      OFS_PERIOD: rd_data = {24'h0, period_q};
      OFS_COUNT:  rd_data = {24'h0, count_q};
      OFS_STATUS: rd_data = {31'h0, flag_q};
      OFS_MASK:   rd_data = {31'h0, mask_q};
      default:    rd_data = '0;
    endcase
  end

  assign O_IRQ = flag_q & mask_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tclk_s;
  logic gate_s;

  gpt_sync #(.W(2)) u_sync (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .i_d    ({I_TIMER_CLOCK_INPUT, I_EXTERNAL_GATE_INPUT}),
    .o_q    ({tclk_s, gate_s})
  );

  // ----------------------------------------------------------------
  // Timer clock edges and enable alignment
  // ----------------------------------------------------------------
  logic       tclk_prev_q, tclk_prev_d;
  logic       tick;
  logic [1:0] run_pipe_q, run_pipe_d;
  logic [1:0] gate_pipe_q, gate_pipe_d;
  logic       run_eff;
  logic       gate_eff;
  logic       gate_ok;
  logic       count_en;

  always_comb begin
    tclk_prev_d = tclk_s;
    // The system clock as timer clock ticks on every cycle.
    tick        = clk_sel ? 1'b1 : (tclk_s & ~tclk_prev_q);
    run_pipe_d  = run_pipe_q;
    gate_pipe_d = gate_pipe_q;
    if (tick) begin
      run_pipe_d  = {run_pipe_q[0], run_bit};
      gate_pipe_d = {gate_pipe_q[0], gate_s};
    end
    if (clk_sel) begin
      run_eff  = run_pipe_q[0];
      gate_eff = gate_pipe_q[0];
    end else begin
      run_eff  = run_pipe_q[SYNC_STAGES-1];
      gate_eff = gate_pipe_q[SYNC_STAGES-1];
    end
    case (mode)
      MODE_SW_GATE: gate_ok = 1'b1;
      MODE_HW_HIGH: gate_ok = gate_eff;
      MODE_HW_LOW:  gate_ok = ~gate_eff;
      default:      gate_ok = 1'b0;
    endcase
    count_en = run_eff & gate_ok;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tclk_prev_q <= 1'b0;
      run_pipe_q  <= '0;
      gate_pipe_q <= '0;
    end else begin
      tclk_prev_q <= tclk_prev_d;
      run_pipe_q  <= run_pipe_d;
      gate_pipe_q <= gate_pipe_d;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, counter and postscaler
  // ----------------------------------------------------------------
  logic [PRE_CNT_W-1:0] pre_cnt_q, pre_cnt_d;
  logic [PRE_CNT_W-1:0] pre_limit;
  logic                 pre_tick;
  logic                 match;
  logic [3:0]           post_cnt_q, post_cnt_d;
  logic                 post_pulse_d;
  logic                 period_match_q, period_match_d;

  always_comb begin
    // Ratio 2^pre_sel; zero gives 1:1.
    pre_limit      = PRE_CNT_W'((8'h01 << pre_sel) - 8'h01);
    pre_cnt_d      = pre_cnt_q;
    pre_tick       = 1'b0;
    count_d        = count_q;
    post_cnt_d     = post_cnt_q;
    post_pulse_d   = 1'b0;
    period_match_d = 1'b0;
    match          = (count_q == period_q);
    // A paused counter simply holds, so the PWM period and high phase
    // stretch by exactly the paused time.
    if (tick && count_en) begin
      if (pre_cnt_q >= pre_limit) begin
        pre_cnt_d = '0;
        pre_tick  = 1'b1;
      end else begin
        pre_cnt_d = pre_cnt_q + 7'h01;
      end
    end
    if (pre_tick) begin
      if (match) begin
        count_d        = COUNT_RST;
        period_match_d = 1'b1;
        if (post_cnt_q >= post_sel) begin
          post_cnt_d   = 4'h0;
          post_pulse_d = 1'b1;
        end else begin
          post_cnt_d = post_cnt_q + 4'h1;
        end
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pre_cnt_q      <= '0;
      count_q        <= COUNT_RST;
      post_cnt_q     <= 4'h0;
      post_pulse_q   <= 1'b0;
      period_match_q <= 1'b0;
    end else begin
      pre_cnt_q      <= pre_cnt_d;
      count_q        <= count_d;
      post_cnt_q     <= post_cnt_d;
      post_pulse_q   <= post_pulse_d;
      period_match_q <= period_match_d;
    end
  end

  assign O_COUNT_VALUE            = count_q;
  assign O_PERIOD_MATCH           = period_match_q;
  assign O_POSTSCALED_MATCH_PULSE = post_pulse_q;

endmodule : gpt_top

// File: verif/gpt_far_end.sv
`timescale 1ns/1ps
module gpt_far_end (
  // Clock and controls from the bench
  input  wire logic i_clk,
  input  wire logic i_tclk_run,
  input  wire logic i_gate_lvl,
  // Pins toward the timer
  output      logic o_tclk,
  output      logic o_gate
);
  logic [1:0] ph_q;

  // Each timer clock level lasts four system clocks; the clock rests low when stopped.
  always @(posedge i_clk) begin
    if (!i_tclk_run) begin
      ph_q <= 2'h0;
      o_tclk <= 1'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3) begin
        o_tclk <= !o_tclk;
      end
    end
  end

  always @(posedge i_clk) begin
    o_gate <= i_gate_lvl;
  end
endmodule : gpt_far_end

// File: verif/gpt_top_sva.sv
`timescale 1ns/1ps
module gpt_top_sva
  import gpt_pkg::*;
(
  // Clock, reset and bus handshakes
  input wire logic             I_CLK,
  input wire logic             I_SRST,
  input wire logic             I_AWVALID,
  input wire logic             O_AWREADY,
  input wire logic             I_WVALID,
  input wire logic             O_WREADY,
  input wire logic             O_BVALID,
  input wire logic             I_BREADY,
  input wire logic             I_ARVALID,
  input wire logic             O_ARREADY,
  input wire logic             O_RVALID,
  input wire logic             I_RREADY,
  // Time base and interrupt
  input wire logic [CNT_W-1:0] O_COUNT_VALUE,
  input wire logic             O_PERIOD_MATCH,
  input wire logic             O_POSTSCALED_MATCH_PULSE,
  input wire logic             O_IRQ
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  a_wrap_zero: assert property (O_PERIOD_MATCH |-> O_COUNT_VALUE == 8'h00)
    else $error("match pulse with nonzero count");
  a_count_step: assert property ($changed(O_COUNT_VALUE) |->
    (O_COUNT_VALUE == $past(O_COUNT_VALUE) + 8'h01) || O_PERIOD_MATCH)
    else $error("count moved by other than one");
  a_post_match: assert property (O_POSTSCALED_MATCH_PULSE |-> O_PERIOD_MATCH)
    else $error("postscaled pulse without match");
  a_irq_cause: assert property ($rose(O_IRQ) |->
    $past(O_POSTSCALED_MATCH_PULSE) || $past(I_WVALID && O_WREADY))
    else $error("interrupt rose without cause");
  a_read_lat: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_write_lat: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> O_BVALID)
    else $error("write answer late");
  a_b_drop: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response not released");
  a_r_drop: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read data not released");
  a_ar_refuse: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read address taken while data pending");
endmodule : gpt_top_sva

bind gpt_top gpt_top_sva i_gpt_top_sva (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_COUNT_VALUE(O_COUNT_VALUE), .O_PERIOD_MATCH(O_PERIOD_MATCH),
  .O_POSTSCALED_MATCH_PULSE(O_POSTSCALED_MATCH_PULSE), .O_IRQ(O_IRQ)
);

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import gpt_pkg::*;
  logic        I_CLK = 1'h0;
  logic        I_SRST = 1'h1;
  logic [7:0]  aw_a = 8'h00, ar_a = 8'h00, v;
  logic [31:0] w_d = 32'h0, d, rd_d;
  logic        aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic        tclk_run = 1'h0, gate = 1'h0, tclk, gpin, awr, wr_r, arr, bv, rv, irq;
  logic        pm, pp;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata;
  logic [7:0]  cnt;
  int          n_fail = 0, tests_run = 0, k, cyc;
  logic [7:0]  ofs [6] = '{OFS_CTRL, OFS_PERIOD, OFS_COUNT, OFS_STATUS, OFS_MASK, 8'h14};
  logic [31:0] rv0 [6] = '{CTRL_RST, 32'h0000_00ff, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0]  seq [3] = '{8'h01, 8'h02, 8'h00};

  always #4 I_CLK = ~I_CLK;

  gpt_far_end i_gpt_far_end (.i_clk(I_CLK), .i_tclk_run(tclk_run), .i_gate_lvl(gate),
    .o_tclk(tclk), .o_gate(gpin));

  gpt_top i_gpt_top (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_AWADDR(aw_a), .I_AWVALID(aw_v),
    .O_AWREADY(awr), .I_WDATA(w_d), .I_WSTRB(4'hf), .I_WVALID(w_v), .O_WREADY(wr_r),
    .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(b_r), .I_ARADDR(ar_a), .I_ARVALID(ar_v),
    .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(r_r),
    .I_TIMER_CLOCK_INPUT(tclk), .I_EXTERNAL_GATE_INPUT(gpin), .O_COUNT_VALUE(cnt),
    .O_PERIOD_MATCH(pm), .O_POSTSCALED_MATCH_PULSE(pp), .O_IRQ(irq));

  // ----------------------------------------------------------------
  // Reporting and bus tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic fail(input string m);
    $display("unexpected %0t %s", $time, m);
    n_fail++;
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rs);
    logic da, dw, ta, tw, db;
    int n;
    da = 1'h0;
    dw = 1'h0;
    db = 1'h0;
    n = 0;
    @(posedge I_CLK);
    aw_a <= a;
    w_d <= dd;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_r <= 1'h1;
    while (!db && n < 100) begin
      @(negedge I_CLK);
      ta = !da && awr;
      tw = !dw && wr_r;
      db = da && dw && bv;
      rs = bresp;
      @(posedge I_CLK);
      if (ta) begin aw_v <= 1'h0; da = 1'h1; end
      if (tw) begin w_v <= 1'h0; dw = 1'h1; end
      if (db) b_r <= 1'h0;
      n++;
    end
    if (!db) begin fail("write hang"); summarize(); end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rs);
    logic da, ta, db;
    int n;
    da = 1'h0;
    db = 1'h0;
    n = 0;
    @(posedge I_CLK);
    ar_a <= a;
    ar_v <= 1'h1;
    r_r <= 1'h1;
    while (!db && n < 100) begin
      @(negedge I_CLK);
      ta = !da && arr;
      db = da && rv;
      dd = rdata;
      rs = rresp;
      @(posedge I_CLK);
      if (ta) begin ar_v <= 1'h0; da = 1'h1; end
      if (db) r_r <= 1'h0;
      n++;
    end
    if (!db) begin fail("read hang"); summarize(); end
  endtask : rd

  task automatic wpulse(input logic post);
    int n;
    n = 0;
    do begin
      @(negedge I_CLK);
      n++;
    end while (!(post ? pp : pm) && n < 3000);
    if (n >= 3000) begin fail("pulse missing"); summarize(); end
  endtask : wpulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge I_CLK);
    I_SRST <= 1'h0;
    for (k = 0; k < 6; k++) begin
      rd(ofs[k], d, r);
      chk(d, rv0[k]);
      chk(32'(r), (k == 5) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
    end
    wr(8'h14, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(OFS_COUNT, 32'h55, r);
    rd(OFS_COUNT, d, r);
    chk(d, 32'h0);
    wr(OFS_PERIOD, 32'h2, r);
    wr(OFS_CTRL, 32'h2001, r);
    @(negedge I_CLK);
    chk(32'(cnt), 32'h0);
    @(negedge I_CLK);
    chk(32'(cnt), 32'h1);
    wpulse(1'h0);
    for (k = 0; k < 6; k++) begin
      @(negedge I_CLK);
      chk(32'(cnt), 32'(seq[k % 3]));
      chk(32'(pm), (k % 3 == 2) ? 32'h1 : 32'h0);
    end
    wr(OFS_CTRL, 32'h2000, r);
    repeat (4) @(negedge I_CLK);
    v = cnt;
    repeat (6) @(negedge I_CLK);
    chk(32'(cnt), 32'(v));
    rd(OFS_STATUS, d, r);
    chk(d, 32'h1);
    chk(32'(irq), 32'h0);
    wr(OFS_MASK, 32'h1, r);
    @(negedge I_CLK);
    chk(32'(irq), 32'h1);
    wr(OFS_STATUS, 32'h1, r);
    rd(OFS_STATUS, d, r);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    wr(OFS_PERIOD, 32'h1, r);
    wr(OFS_CTRL, 32'h2601, r);
    wpulse(1'h1);
    k = 0;
    cyc = 0;
    do begin
      @(negedge I_CLK);
      if (pm) k++;
      cyc++;
    end while (!pp && cyc < 3000);
    if (!pp) begin fail("pulse missing"); summarize(); end
    chk(32'(k), 32'h4);
    chk(32'(irq), 32'h1);
    wr(OFS_PERIOD, 32'hff, r);
    wr(OFS_MASK, 32'h0, r);
    for (k = 1; k < 3; k++) begin
      @(posedge I_CLK);
      gate <= (k == 2);
      wr(OFS_CTRL, 32'h2001 | (k << 1), r);
      repeat (4) @(negedge I_CLK);
      v = cnt;
      repeat (6) @(negedge I_CLK);
      chk(32'(cnt), 32'(v));
      @(posedge I_CLK);
      gate <= (k == 1);
      repeat (6) @(negedge I_CLK);
      chk(32'(cnt != v), 32'h1);
    end
    wr(OFS_CTRL, 32'h0003, r);
    @(posedge I_CLK);
    tclk_run <= 1'h1;
    gate <= 1'h1;
    repeat (24) @(negedge I_CLK);
    v = cnt;
    repeat (80) @(negedge I_CLK);
    v = cnt - v;
    chk(32'(v >= 8'h09 && v <= 8'h0b), 32'h1);
    @(posedge I_CLK);
    gate <= 1'h0;
    @(negedge I_CLK);
    v = cnt;
    repeat (80) @(negedge I_CLK);
    v = cnt - v;
    chk(32'(v >= 8'h02 && v <= 8'h03), 32'h1);
    summarize();
  end
endmodule : tb
